// >>> src/i2c_status_pkg.sv
package i2c_status_pkg;

	// register byte offsets on the avalon slave
	localparam logic [7:0] OFF_IRQ_MASK    = 8'h04;
	localparam logic [7:0] OFF_STATUS      = 8'h08;
	localparam logic [7:0] OFF_HOLD        = 8'h18;
	localparam logic [7:0] OFF_MODE        = 8'h24;
	localparam logic [7:0] OFF_IRQ_STATUS  = 8'h40;

	// status flag positions
	localparam int BIT_SLAVE_DIR   = 14;
	localparam int BIT_NACK_SENT   = 13;
	localparam int BIT_BUS_BUSY    = 12;
	localparam int BIT_OVERRUN     = 11;

	// mode control positions
	localparam int BIT_MODULE_RESET_N = 0;
	localparam int BIT_START_REQUEST  = 1;
	localparam int BIT_LOOPBACK       = 2;

	// reset values
	localparam logic [2:0] MODE_RESET     = 3'h0;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
	localparam logic [7:0] HOLD_RESET     = 8'h00;

	// data word length and bit counter slot values
	localparam int          WORD_BITS    = 8;
	localparam logic [3:0]  LAST_DATA    = 4'h7;
	localparam logic [3:0]  ACK_SLOT     = 4'h8;

	// bus pin levels after sampling
	typedef struct packed {
		logic scl;                        // clock line level
		logic sda;                        // data line level
	} pin_levels_t;

	// interrupt event bits, high to low
	typedef struct packed {
		logic nackSent;                   // nack driven by us
		logic overrun;                    // receive overrun began
		logic stopSeen;                   // stop on the bus
		logic startSeen;                  // start on the bus
	} irq_bits_t;

endpackage : i2c_status_pkg

// >>> src/i2c_pin_sync.sv
module i2c_pin_sync (
	input  wire logic                        clock,    // module clock
	input  wire logic                        reset_n,  // async reset
	input  wire i2c_status_pkg::pin_levels_t pinsIn,   // raw pin levels
	output i2c_status_pkg::pin_levels_t      pinsOut   // filtered levels
);

	i2c_status_pkg::pin_levels_t stage1Reg;            // first sampler
	i2c_status_pkg::pin_levels_t stage2Reg;            // second sampler
	i2c_status_pkg::pin_levels_t stage3Reg;            // third sampler
	i2c_status_pkg::pin_levels_t levelReg;             // accepted level

	// three sampling stages; the first is read only by the second
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stage1Reg <= '1;
			stage2Reg <= '1;
			stage3Reg <= '1;
		end
		else
		begin
			stage1Reg <= pinsIn;
			stage2Reg <= stage1Reg;
			stage3Reg <= stage2Reg;
		end
	end

	// a line change counts once stages two and three agree
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			levelReg <= '1;
		else
		begin
			if (stage2Reg.scl == stage3Reg.scl)
				levelReg.scl <= stage3Reg.scl;
			if (stage2Reg.sda == stage3Reg.sda)
				levelReg.sda <= stage3Reg.sda;
		end
	end

	assign pinsOut = levelReg;

endmodule : i2c_pin_sync

// >>> src/i2c_status_flag_logic.sv
// Notes on behaviour
// R1: reserved status bits read zero, writes ignored
// R2: loopback mode holds slave direction at zero
// R3: slave direction set only as slave-transmitter
// R4: start or stop clears slave direction
// R5: writing one clears slave direction
// R6: nack driven as receiver sets nack-sent
// R7: nack-sent cleared by w1c or resets
// R8: stop on bus clears bus busy
// R9: bus busy cleared by w1c or resets
// R10: start on bus sets bus busy
// R11: clock low in module reset sets busy
// R12: start request while busy makes restart
// R13: full shift word, unread holding sets overrun
// R14: no transfer to holding until read
// R15: shifting continues during overrun, overwriting
// R16: hardware set beats software clear
module i2c_status_flag_logic (
	input  wire logic        clock,           // 50 MHz module clock
	input  wire logic        reset_n,         // device reset, async
	input  wire logic [7:0]  address,         // avalon byte address
	input  wire logic        read,            // avalon read
	input  wire logic        write,           // avalon write
	input  wire logic [3:0]  byteenable,      // avalon byte lanes
	input  wire logic [31:0] writedata,       // avalon write data
	output logic [31:0]      readdata,        // avalon read data
	output logic             waitrequest,     // avalon wait
	input  wire logic        sclPin,          // scl line level
	input  wire logic        sdaPin,          // sda line level
	input  wire logic        slaveTxBegin,    // pulse: now slave-tx
	input  wire logic        nackDriven,      // pulse: we sent nack
	output logic             restartPulse,    // pulse: make restart
	output logic             irq              // level interrupt
);

	i2c_status_pkg::pin_levels_t pinLevels;   // filtered pin levels
	logic        sclPrevReg;                  // scl one cycle ago
	logic        sdaPrevReg;                  // sda one cycle ago
	logic        ackReg;                      // bus answer cycle
	logic [31:0] readdataReg;                 // captured read word
	logic [2:0]  modeReg;                     // mode control bits
	logic [3:0]  maskReg;                     // interrupt mask
	i2c_status_pkg::irq_bits_t irqReg;        // sticky events
	i2c_status_pkg::irq_bits_t irqEvents;     // this cycle's events
	logic        slaveDirReg;                 // slave direction flag
	logic        nackSentReg;                 // nack sent flag
	logic        busBusyReg;                  // bus busy flag
	logic        overrunReg;                  // receive overrun flag
	logic [7:0]  shiftReg;                    // receive shift register
	logic [3:0]  bitCntReg;                   // bit slot in the word
	logic [7:0]  holdReg;                     // receive holding reg
	logic        holdFullReg;                 // holding not yet read
	logic        restartReg;                  // restart pulse flop
	logic        startSeen;                   // start detected
	logic        stopSeen;                    // stop detected
	logic        sclRise;                     // scl rising edge
	logic        wordDone;                    // eighth bit shifted
	logic        readAcc;                     // read taken
	logic        writeAcc;                    // write taken
	logic [31:0] wrData;                      // lane-masked write data
	logic [31:0] statusWord;                  // status read value
	logic        w1cSlaveDir;                 // clear request bit 14
	logic        w1cNackSent;                 // clear request bit 13
	logic        w1cBusBusy;                  // clear request bit 12
	logic        modeWrite;                   // mode register written
	logic        moduleResetWrite;            // zero to module reset
	logic        holdRead;                    // holding register read
	logic        loopback;                    // loopback mode on
	logic        moduleRunning;               // module out of reset

	// byte lanes expanded to a bit mask
	function automatic logic [31:0] laneMask(input logic [3:0] be);
		laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : laneMask

	// word-aligned address decode
	function automatic logic regHit(input logic [7:0] addr,
		input logic [7:0] off);
		regHit = (addr[7:2] == off[7:2]);
	endfunction : regHit

	// bus pins pass the three-stage sampler
	i2c_pin_sync pinSync (
		.clock   (clock),
		.reset_n (reset_n),
		.pinsIn  (i2c_status_pkg::pin_levels_t'{scl: sclPin, sda: sdaPin}),
		.pinsOut (pinLevels)
	);

	// previous levels for edge and condition detection
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sclPrevReg <= 1'b1;
			sdaPrevReg <= 1'b1;
		end
		else
		begin
			sclPrevReg <= pinLevels.scl;
			sdaPrevReg <= pinLevels.sda;
		end
	end

	// start: sda falls with scl high; stop: sda rises with scl high
	assign startSeen = pinLevels.scl & sclPrevReg & sdaPrevReg
		& ~pinLevels.sda;
	assign stopSeen  = pinLevels.scl & sclPrevReg & ~sdaPrevReg
		& pinLevels.sda;
	assign sclRise   = pinLevels.scl & ~sclPrevReg;

	// avalon handshake: one wait cycle, answer on the next edge
	assign waitrequest = (read | write) & ~ackReg;
	assign readAcc     = read & ackReg;
	assign writeAcc    = write & ackReg;
	assign wrData      = writedata & laneMask(byteenable);
	assign readdata    = readdataReg;

	// decoded side effects of accepted accesses
	assign modeWrite   = writeAcc & regHit(address, i2c_status_pkg::OFF_MODE);
	assign moduleResetWrite = modeWrite & byteenable[0]
		& ~writedata[i2c_status_pkg::BIT_MODULE_RESET_N];
	assign w1cSlaveDir = writeAcc
		& regHit(address, i2c_status_pkg::OFF_STATUS)
		& wrData[i2c_status_pkg::BIT_SLAVE_DIR];
	assign w1cNackSent = writeAcc
		& regHit(address, i2c_status_pkg::OFF_STATUS)
		& wrData[i2c_status_pkg::BIT_NACK_SENT];
	assign w1cBusBusy  = writeAcc
		& regHit(address, i2c_status_pkg::OFF_STATUS)
		& wrData[i2c_status_pkg::BIT_BUS_BUSY];
	assign holdRead    = readAcc & regHit(address, i2c_status_pkg::OFF_HOLD);
	assign loopback    = modeReg[i2c_status_pkg::BIT_LOOPBACK];
	assign moduleRunning = modeReg[i2c_status_pkg::BIT_MODULE_RESET_N];

	// status word: upper reserved bits and others read zero
	always_comb
	begin
		statusWord = 32'h0000_0000; // R1
		statusWord[i2c_status_pkg::BIT_SLAVE_DIR] = slaveDirReg;
		statusWord[i2c_status_pkg::BIT_NACK_SENT] = nackSentReg;
		statusWord[i2c_status_pkg::BIT_BUS_BUSY]  = busBusyReg;
		statusWord[i2c_status_pkg::BIT_OVERRUN]   = overrunReg;
	end

	// answer flop: high for the one cycle the access is taken
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			ackReg <= 1'b0;
		else
			ackReg <= (read | write) & ~ackReg;
	end

	// read data captured in the wait cycle, unmapped reads zero
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			readdataReg <= 32'h0000_0000;
		else if (read & ~ackReg)
		begin
			if (regHit(address, i2c_status_pkg::OFF_STATUS))
				readdataReg <= statusWord;
			else if (regHit(address, i2c_status_pkg::OFF_HOLD))
				readdataReg <= {24'h00_0000, holdReg};
			else if (regHit(address, i2c_status_pkg::OFF_MODE))
				readdataReg <= {29'h0000_0000, modeReg};
			else if (regHit(address, i2c_status_pkg::OFF_IRQ_MASK))
				readdataReg <= {28'h000_0000, maskReg};
			else if (regHit(address, i2c_status_pkg::OFF_IRQ_STATUS))
				readdataReg <= {28'h000_0000, irqReg};
			else
				readdataReg <= 32'h0000_0000;
		end
	end

	// mode control; start request drops once a start is seen
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			modeReg <= i2c_status_pkg::MODE_RESET;
		else if (modeWrite & byteenable[0])
			modeReg <= writedata[2:0];
		else if (startSeen)
			modeReg[i2c_status_pkg::BIT_START_REQUEST] <= 1'b0;
	end

	// restart request when start is asked while the bus is busy
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			restartReg <= 1'b0;
		else
			restartReg <= modeWrite & byteenable[0] & busBusyReg
				& writedata[i2c_status_pkg::BIT_START_REQUEST]; // R12
	end
	assign restartPulse = restartReg;

	// slave direction flag
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			slaveDirReg <= 1'b0;
		else if (loopback)
			slaveDirReg <= 1'b0; // R2
		else if (startSeen | stopSeen)
			slaveDirReg <= 1'b0; // R4
		else if (slaveTxBegin)
			slaveDirReg <= 1'b1; // R3 R16
		else if (w1cSlaveDir)
			slaveDirReg <= 1'b0; // R5
	end

	// nack sent flag
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			nackSentReg <= 1'b0; // R7
		else if (nackDriven)
			nackSentReg <= 1'b1; // R6 R16
		else if (w1cNackSent | moduleResetWrite)
			nackSentReg <= 1'b0; // R7
	end

	// bus busy flag
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			busBusyReg <= 1'b0; // R9
		else if (startSeen)
			busBusyReg <= 1'b1; // R10 R16
		else if (~moduleRunning & ~pinLevels.scl)
			busBusyReg <= 1'b1; // R11 R16
		else if (stopSeen)
			busBusyReg <= 1'b0; // R8
		else if (w1cBusBusy | moduleResetWrite)
			busBusyReg <= 1'b0; // R9
	end

	// receive shifter: sda taken on each data-bit scl rise while busy; the ack-slot rise only resets the count
	assign wordDone = sclRise & busBusyReg & (bitCntReg == 
		i2c_status_pkg::LAST_DATA);

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			shiftReg  <= 8'h00;
			bitCntReg <= 4'h0;
		end
		else if (startSeen)
			bitCntReg <= 4'h0;
		else if (sclRise & busBusyReg)
		begin
			if (bitCntReg == i2c_status_pkg::ACK_SLOT)
				bitCntReg <= 4'h0;
			else
			begin
				shiftReg  <= {shiftReg[6:0], pinLevels.sda}; // R15
				bitCntReg <= 4'(bitCntReg + 4'h1);
			end
		end
	end

	// holding register and overrun flag
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			holdReg     <= i2c_status_pkg::HOLD_RESET;
			holdFullReg <= 1'b0;
			overrunReg  <= 1'b0;
		end
		else if (wordDone & holdFullReg & ~holdRead)
			overrunReg <= 1'b1; // R13
		else if (wordDone)
		begin
			holdReg     <= {shiftReg[6:0], pinLevels.sda};
			holdFullReg <= 1'b1;
			overrunReg  <= 1'b0;
		end
		else if (holdRead & overrunReg)
		begin
			holdReg    <= shiftReg; // R14
			overrunReg <= 1'b0;
		end
		else if (holdRead)
			holdFullReg <= 1'b0;
	end

	// interrupt events and sticky status, read clears, set wins
	assign irqEvents = '{nackSent:  nackDriven,
		overrun:   wordDone & holdFullReg & ~holdRead & ~overrunReg,
		stopSeen:  stopSeen,
		startSeen: startSeen};

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			irqReg <= '0;
		else if (readAcc & regHit(address, i2c_status_pkg::OFF_IRQ_STATUS))
			irqReg <= irqEvents; // R16
		else
			irqReg <= irqReg | irqEvents;
	end

	// interrupt mask register
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			maskReg <= i2c_status_pkg::IRQ_MASK_RESET;
		else if (writeAcc & byteenable[0]
			& regHit(address, i2c_status_pkg::OFF_IRQ_MASK))
			maskReg <= writedata[3:0];
	end

	assign irq = |(irqReg & maskReg);

	// checks on the flag behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_status_read;
		read & ~ackReg & regHit(address, i2c_status_pkg::OFF_STATUS);
	endsequence

	sequence s_restart_ask;
		modeWrite & byteenable[0] & busBusyReg
			& writedata[i2c_status_pkg::BIT_START_REQUEST];
	endsequence

	property p_reserved_zero;
		s_status_read |=> (readdataReg[31:15] == 17'h0_0000)
			&& (readdataReg[10:0] == 11'h000);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // R1
		else $error("reserved status bits not zero");

	property p_loopback_dir;
		loopback |=> !slaveDirReg;
	endproperty
	a_loopback_dir: assert property (p_loopback_dir) // R2
		else $error("slave direction set in loopback");

	property p_dir_set;
		slaveTxBegin & ~loopback & ~startSeen & ~stopSeen
			|=> slaveDirReg;
	endproperty
	a_dir_set: assert property (p_dir_set) // R3
		else $error("slave direction not set");

	property p_dir_cond_clear;
		(startSeen | stopSeen) |=> !slaveDirReg;
	endproperty
	a_dir_cond_clear: assert property (p_dir_cond_clear) // R4
		else $error("slave direction kept over start or stop");

	property p_dir_w1c;
		w1cSlaveDir & ~slaveTxBegin |=> !slaveDirReg;
	endproperty
	a_dir_w1c: assert property (p_dir_w1c) // R5
		else $error("slave direction not cleared by write");

	property p_nack_set_wins;
		nackDriven |=> nackSentReg;
	endproperty
	a_nack_set_wins: assert property (p_nack_set_wins) // R6 R16
		else $error("nack sent flag not set");

	property p_nack_clear;
		(w1cNackSent | moduleResetWrite) & ~nackDriven |=> !nackSentReg;
	endproperty
	a_nack_clear: assert property (p_nack_clear) // R7
		else $error("nack sent flag not cleared");

	property p_busy_stop;
		stopSeen & moduleRunning |=> !busBusyReg;
	endproperty
	a_busy_stop: assert property (p_busy_stop) // R8
		else $error("bus busy kept after stop");

	property p_busy_clear;
		(w1cBusBusy | moduleResetWrite) & ~startSeen & moduleRunning
			& pinLevels.scl |=> !busBusyReg;
	endproperty
	a_busy_clear: assert property (p_busy_clear) // R9
		else $error("bus busy not cleared");

	property p_busy_start;
		startSeen |=> busBusyReg;
	endproperty
	a_busy_start: assert property (p_busy_start) // R10
		else $error("bus busy not set on start");

	property p_busy_scl_low;
		~moduleRunning & ~pinLevels.scl |=> busBusyReg;
	endproperty
	a_busy_scl_low: assert property (p_busy_scl_low) // R11
		else $error("bus busy not set with scl low");

	property p_restart;
		s_restart_ask |=> restartPulse ##1 !restartPulse;
	endproperty
	a_restart: assert property (p_restart) // R12
		else $error("restart pulse wrong");

	property p_overrun_set;
		wordDone & holdFullReg & ~holdRead |=> overrunReg;
	endproperty
	a_overrun_set: assert property (p_overrun_set) // R13
		else $error("overrun not flagged");

	property p_hold_kept;
		overrunReg & ~holdRead |=> $stable(holdReg);
	endproperty
	a_hold_kept: assert property (p_hold_kept) // R14
		else $error("holding register overwritten in overrun");

	property p_shift_on;
		overrunReg & sclRise & busBusyReg & ~startSeen
			& (bitCntReg != i2c_status_pkg::ACK_SLOT)
			|=> shiftReg[0] == $past(pinLevels.sda);
	endproperty
	a_shift_on: assert property (p_shift_on) // R15
		else $error("shifting stopped in overrun");

endmodule : i2c_status_flag_logic

// >>> sim/i2c_bus_model.sv
// other device on the wire: drives both lines, idle high by pull-up
module i2c_bus_model (
	input  wire logic clock, // module clock, paces the link
	output logic      scl,   // clock line level seen by the block
	output logic      sda    // data line level seen by the block
);
	timeunit 1ns;
	timeprecision 1ps;

	// lines released at start: pull-ups hold them high
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// half a link period of 80 ns is four module cycles
	task automatic w(input int n);
		repeat (n) @(posedge clock);
	endtask : w

	// start or repeated start, clock left low afterwards
	task automatic startCond();
		w(1);
		sda <= 1'b1;
		w(4);
		scl <= 1'b1;
		w(4);
		sda <= 1'b0;
		w(4);
		scl <= 1'b0;
		w(4);
	endtask : startCond

	// stop: data rises while the clock is high, then the link idles
	task automatic stopCond();
		w(1);
		sda <= 1'b0;
		w(4);
		scl <= 1'b1;
		w(4);
		sda <= 1'b1;
		w(8);
	endtask : stopCond

	// one word, msb first, then the ack slot with the line released
	task automatic sendByte(input logic [7:0] d);
		for (int i = 7; i >= -1; i--)
		begin
			w(1);
			sda <= (i >= 0) ? d[i] : 1'b1;
			w(4);
			scl <= 1'b1;
			w(4);
			scl <= 1'b0;
		end
		w(4);
	endtask : sendByte
endmodule : i2c_bus_model

// >>> sim/testbench.sv
// self-checking bench for the status flag block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// one register access with its expected read-back
	typedef struct packed {
		logic [7:0]  a;  // address
		logic [31:0] wd; // write data
		logic [3:0]  be; // byte lanes
		logic [31:0] e;  // expected read-back
	} row_t;

	logic        clock = 1'b0;       // module clock
	logic        reset_n = 1'b0;     // device reset
	logic [7:0]  address = 8'h00;    // avalon address
	logic        read = 1'b0;        // avalon read
	logic        write = 1'b0;       // avalon write
	logic [3:0]  byteenable = 4'h0;  // avalon lanes
	logic [31:0] writedata = 32'h0;  // avalon write data
	logic [31:0] readdata;           // avalon read data
	logic        waitrequest;        // avalon wait
	logic        scl;                // clock line from the model
	logic        sda;                // data line from the model
	logic        slaveTxBegin = 1'b0; // slave-tx pulse
	logic        nackDriven = 1'b0;  // nack pulse
	logic        restartPulse;       // restart request out
	logic        irq;                // interrupt out
	logic [31:0] rd;                 // last read value
	int          n_fail = 0;         // mismatches
	int          num_checks = 0;     // comparisons

	// register table rows: reserved, unmapped, lanes, read-only
	row_t rows [7] = '{
		'{8'h04, 32'hffffffff, 4'hf, 32'h0000000f},
		'{8'h04, 32'h0000000a, 4'he, 32'h0000000f},
		'{8'h08, 32'hffff8000, 4'hf, 32'h00000000},
		'{8'h3c, 32'hffffffff, 4'hf, 32'h00000000},
		'{8'h18, 32'hffffffff, 4'hf, 32'h00000000},
		'{8'h24, 32'h00000005, 4'hf, 32'h00000005},
		'{8'h24, 32'h00000001, 4'hf, 32'h00000001}
	};

	// 50 MHz clock
	always #10 clock = ~clock;

	i2c_status_flag_logic dut_u (
		.clock        (clock),
		.reset_n      (reset_n),
		.address      (address),
		.read         (read),
		.write        (write),
		.byteenable   (byteenable),
		.writedata    (writedata),
		.readdata     (readdata),
		.waitrequest  (waitrequest),
		.sclPin       (scl),
		.sdaPin       (sda),
		.slaveTxBegin (slaveTxBegin),
		.nackDriven   (nackDriven),
		.restartPulse (restartPulse),
		.irq          (irq)
	);

	i2c_bus_model busModel (
		.clock (clock),
		.scl   (scl),
		.sda   (sda)
	);

	// counts and reports one comparison
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	// holds the request until waitrequest is sampled low at a rising
	// edge; only the watchdog ends a wait that never finishes
	task automatic waitTaken();
		int k;
		k = 0;
		forever
		begin
			@(posedge clock);
			if (!waitrequest)
				break;
			k++;
		end
		check(k, 32'h1);
	endtask : waitTaken

	task automatic busWrite(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be = 4'hf);
		@(posedge clock);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= 1'b1;
		waitTaken();
		write <= 1'b0;
	endtask : busWrite

	task automatic busRead(input logic [7:0] a);
		@(posedge clock);
		address <= a;
		read <= 1'b1;
		waitTaken();
		rd = readdata;
		read <= 1'b0;
	endtask : busRead

	// reads a register and compares it
	task automatic expectReg(input logic [7:0] a, input logic [31:0] e);
		busRead(a);
		check(rd, e);
	endtask : expectReg

	// one-cycle pulse on a side input: 1 nack, 0 slave-tx
	task automatic pulseIn(input bit nack);
		@(posedge clock);
		if (nack)
			nackDriven <= 1'b1;
		else
			slaveTxBegin <= 1'b1;
		@(posedge clock);
		nackDriven <= 1'b0;
		slaveTxBegin <= 1'b0;
	endtask : pulseIn

	// watchdog: the sequence needs a few hundred cycles
	initial
	begin
		#400000;
		n_fail++;
		test_done();
	end

	// main sequence
	initial
	begin
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		expectReg(8'h08, 32'h0);
		for (int i = 0; i < 7; i++)
		begin
			busWrite(rows[i].a, rows[i].wd, rows[i].be);
			expectReg(rows[i].a, rows[i].e);
		end
		expectReg(8'h40, 32'h0);
		// start on the bus, interrupt raised, masked, cleared
		busModel.startCond();
		expectReg(8'h08, 32'h00001000);
		check({31'h0, irq}, 32'h1);
		busWrite(8'h04, 32'h0);
		@(negedge clock);
		check({31'h0, irq}, 32'h0);
		busWrite(8'h04, 32'hf);
		expectReg(8'h40, 32'h1);
		@(negedge clock);
		check({31'h0, irq}, 32'h0);
		// slave direction set, write-one clear, cleared by restart
		pulseIn(1'b0);
		expectReg(8'h08, 32'h00005000);
		busWrite(8'h08, 32'h00004000);
		expectReg(8'h08, 32'h00001000);
		pulseIn(1'b0);
		busModel.startCond();
		expectReg(8'h08, 32'h00001000);
		// start request while busy gives one restart pulse
		busWrite(8'h24, 32'h3);
		@(negedge clock);
		check({31'h0, restartPulse}, 32'h1);
		@(negedge clock);
		check({31'h0, restartPulse}, 32'h0);
		// nack-sent set and cleared; set wins over the clear
		pulseIn(1'b1);
		expectReg(8'h08, 32'h00003000);
		busWrite(8'h08, 32'h00002000);
		expectReg(8'h08, 32'h00001000);
		fork
			busWrite(8'h08, 32'h00002000);
			begin
				repeat (2) @(posedge clock);
				nackDriven <= 1'b1;
				@(posedge clock);
				nackDriven <= 1'b0;
			end
		join
		expectReg(8'h08, 32'h00003000);
		// module reset clears nack and busy; clock low sets busy again
		busWrite(8'h24, 32'h0);
		repeat (8) @(posedge clock);
		expectReg(8'h08, 32'h00001000);
		busWrite(8'h24, 32'h1);
		busWrite(8'h08, 32'h00001000);
		expectReg(8'h08, 32'h0);
		// overrun: three words, holding keeps the first until read
		busModel.startCond();
		busModel.sendByte(8'ha5);
		busModel.sendByte(8'h3c);
		busModel.sendByte(8'h5a);
		expectReg(8'h08, 32'h00001800);
		expectReg(8'h18, 32'h000000a5);
		expectReg(8'h08, 32'h00001000);
		expectReg(8'h18, 32'h0000005a);
		busModel.stopCond();
		expectReg(8'h08, 32'h0);
		// loopback holds slave direction low
		busWrite(8'h24, 32'h5);
		pulseIn(1'b0);
		expectReg(8'h08, 32'h0);
		// device reset in mid-run clears nack and busy, then scl low
		// with the module held in reset sets busy again
		pulseIn(1'b1);
		busModel.startCond();
		expectReg(8'h08, 32'h00003000);
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		expectReg(8'h08, 32'h0);
		expectReg(8'h24, 32'h0);
		check({31'h0, irq}, 32'h0);
		repeat (4) @(posedge clock);
		expectReg(8'h08, 32'h00001000);
		test_done();
	end
endmodule : testbench
